// ---- common/psq_pkg.sv ----
// Package of constants, types and register map for the triple buck sequencer
package psq_pkg;

   // ----------------------------------------
   // Timing
   // ----------------------------------------
   localparam int CLK_PERIOD_NS = 25;
   localparam int SOFTSTART_US = 1000;
   localparam int OC_WAIT_US = 500;
   localparam int HICCUP_US = 14000;
   localparam int PG_DEGLITCH_US = 100;
   // Least times, rounded up to whole cycles
   localparam int SOFTSTART_CYC = (SOFTSTART_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int OC_WAIT_CYC = (OC_WAIT_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int HICCUP_CYC = (HICCUP_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int PG_DEGLITCH_CYC = (PG_DEGLITCH_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int CNT_W = 20;
   localparam int NBUCK = 3;

   // ----------------------------------------
   // Register map (byte addresses)
   // ----------------------------------------
   localparam logic [7:0] ADDR_CTRL = 8'h00;
   localparam logic [7:0] ADDR_STATUS = 8'h04;
   localparam logic [7:0] ADDR_IRQ_STAT = 8'h08;
   localparam logic [7:0] ADDR_IRQ_MASK = 8'h0c;
   localparam int CTRL_HOLD_BIT = 0;
   localparam logic CTRL_RESET = 1'h0;
   localparam int NEVT = 6;
   localparam logic [NEVT-1:0] IRQ_MASK_RESET = 6'h00;
   localparam int EVT_PG_RISE = 0;
   localparam int EVT_PG_FALL = 1;
   localparam int EVT_HICCUP = 2;
   localparam int EVT_THERMAL = 3;
   localparam int EVT_LOCKOUT = 4;
   localparam int EVT_SEQ_DONE = 5;

   // ----------------------------------------
   // Types
   // ----------------------------------------
   typedef enum logic [1:0] {
      BK_OFF = 2'b00,
      BK_SOFT = 2'b01,
      BK_ON = 2'b10,
      BK_HICCUP = 2'b11
   } psq_buck_e;

   typedef enum logic [1:0] {
      SQ_IDLE = 2'b00,
      SQ_UP = 2'b01,
      SQ_ALLON = 2'b10,
      SQ_DOWN = 2'b11
   } psq_seq_e;

   typedef struct packed {
      logic startstop;
      logic buck2;
      logic buck1;
   } psq_enables_s;

   typedef struct packed {
      logic hold_off;
   } psq_ctrl_s;

endpackage : psq_pkg

// ---- src/psq_sequencer.sv ----
// Triple buck start/stop sequencer with lockout, soft start, hiccup and power good
`timescale 1ns/100ps
// Summary of operation
// - Sequencing mode high: bucks start and stop in a fixed order.
// - Sequencing mode low: each buck follows its own enable independently.
// - Enables 1 and 2 pick one of three orders; both low is reserved.
// - Third enable launches start order on rise, matching stop order on fall.
// - Independent mode: enable high runs the buck, low stops it quietly.
// - Supply lockout disables everything; the detector itself carries the hysteresis.
// - Bucks 2 and 3 soft start over a fixed 1 ms interval.
// - Regulation flag rises only after a continuous deglitch interval in regulation.
// - Driver supply turns on at the low wake level of any enable.
// - Regulation flag low in lockout, thermal stop, enable low or soft start.
// - Overcurrent beyond 0.5 ms shuts a buck down; restart after 14 ms.
// - Thermal shutdown stops switching; power-up reruns once it clears.
module psq_sequencer
   import psq_pkg::*;
#(
   parameter logic [CNT_W-1:0] SS_CYC = CNT_W'(SOFTSTART_CYC),
   parameter logic [CNT_W-1:0] OCW_CYC = CNT_W'(OC_WAIT_CYC),
   parameter logic [CNT_W-1:0] HIC_CYC = CNT_W'(HICCUP_CYC)
) (
   input wire logic clk,
   input wire logic rst,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic sequencing_mode,
   input wire psq_enables_s enables,
   input wire logic [NBUCK-1:0] enable_wake,
   input wire logic input_low_lockout,
   input wire logic over_temp,
   input wire logic [NBUCK-1:0] overcurrent,
   input wire logic [NBUCK-1:0] in_regulation,
   input wire logic ramp_pin_buck1_done,
   output logic [NBUCK-1:0] buck_run,
   output logic [NBUCK-1:0] buck_soft_start,
   output logic internal_driver_supply,
   output logic output_regulation_ok,
   output logic irq
);

   // ----------------------------------------
   // Order table
   // ----------------------------------------
   // sel is {enable_buck2, enable_buck1}; returns the buck index at a step
   function automatic logic [1:0] seq_buck(input logic [1:0] sel, input logic [1:0] step);
      logic [1:0] b;
      b = step;
      case (sel)
         2'b11: b = step;
         2'b10: b = (step == 2'h0) ? 2'h1 : (step == 2'h1) ? 2'h0 : 2'h2;
         2'b01: b = (step == 2'h0) ? 2'h1 : (step == 2'h1) ? 2'h2 : 2'h0;
         default: b = step;
      endcase
      return b;
   endfunction : seq_buck

   // ----------------------------------------
   // Common conditions
   // ----------------------------------------
   psq_ctrl_s ctrl_q;
   logic kill;
   logic [1:0] sel_in;
   logic [NBUCK-1:0] en_vec;
   assign kill = input_low_lockout | over_temp | ctrl_q.hold_off;
   assign sel_in = {enables.buck2, enables.buck1};
   assign en_vec = {enables.startstop, enables.buck2, enables.buck1};

   // ----------------------------------------
   // Automatic sequencer
   // ----------------------------------------
   psq_seq_e sq_q;
   logic [1:0] step_q;
   logic [1:0] sel_q;
   logic [NBUCK-1:0] seq_req_q;
   psq_buck_e st_q [NBUCK];
   logic [1:0] up_b;
   logic [1:0] dn_b;
   logic seq_done_evt;

   assign up_b = seq_buck(sel_q, step_q);
   assign dn_b = seq_buck(sel_q, 2'h2 - step_q);
   assign seq_done_evt = (sq_q == SQ_UP) && (step_q == 2'h2) && (st_q[up_b] == BK_ON)
                         && in_regulation[up_b] && enables.startstop && (sel_in == sel_q);

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         sq_q <= SQ_IDLE;
         step_q <= 2'h0;
         sel_q <= 2'h0;
         seq_req_q <= 3'h0;
      end else if (kill || !sequencing_mode) begin
         // Thermal recovery restarts from idle so the whole order reruns
         sq_q <= SQ_IDLE;
         step_q <= 2'h0;
         seq_req_q <= 3'h0;
      end else begin
         case (sq_q)
            SQ_IDLE: begin
               if (enables.startstop && (sel_in != 2'b00)) begin
                  sel_q <= sel_in;
                  step_q <= 2'h0;
                  sq_q <= SQ_UP;
               end
            end
            SQ_UP: begin
               if (!enables.startstop || (sel_in != sel_q)) begin
                  step_q <= 2'h0;
                  sq_q <= SQ_DOWN;
               end else begin
                  seq_req_q[up_b] <= 1'b1;
                  if ((st_q[up_b] == BK_ON) && in_regulation[up_b]) begin
                     if (step_q == 2'h2) begin
                        sq_q <= SQ_ALLON;
                     end else begin
                        step_q <= step_q + 2'h1;
                     end
                  end
               end
            end
            SQ_ALLON: begin
               if (!enables.startstop || (sel_in != sel_q)) begin
                  step_q <= 2'h0;
                  sq_q <= SQ_DOWN;
               end
            end
            SQ_DOWN: begin
               seq_req_q[dn_b] <= 1'b0;
               if (st_q[dn_b] == BK_OFF && !seq_req_q[dn_b]) begin
                  if (step_q == 2'h2) begin
                     sq_q <= SQ_IDLE;
                  end else begin
                     step_q <= step_q + 2'h1;
                  end
               end
            end
            default: sq_q <= SQ_IDLE;
         endcase
      end
   end

   // ----------------------------------------
   // Per-buck state
   // ----------------------------------------
   logic [CNT_W-1:0] cnt_q [NBUCK];
   logic [NBUCK-1:0] run_req;
   logic [NBUCK-1:0] soft_done;
   logic [NBUCK-1:0] hiccup_evt;

   assign run_req = sequencing_mode ? seq_req_q : en_vec;

   genvar gi;
   generate
      for (gi = 0; gi < NBUCK; gi++) begin : g_buck
         if (gi == 0) begin : g_ext
            // Buck 1 ramp length is set by the external pin capacitor
            assign soft_done[gi] = ramp_pin_buck1_done;
         end else begin : g_int
            assign soft_done[gi] = (cnt_q[gi] >= SS_CYC - CNT_W'(1));
         end
         assign hiccup_evt[gi] = (st_q[gi] == BK_ON) && overcurrent[gi] && !kill
                                 && run_req[gi] && (cnt_q[gi] >= OCW_CYC - CNT_W'(1));
         assign buck_run[gi] = (st_q[gi] == BK_SOFT) || (st_q[gi] == BK_ON);
         assign buck_soft_start[gi] = (st_q[gi] == BK_SOFT);

         always_ff @(posedge clk or posedge rst) begin
            if (rst) begin
               st_q[gi] <= BK_OFF;
               cnt_q[gi] <= '0;
            end else if (kill || !run_req[gi]) begin
               st_q[gi] <= BK_OFF;
               cnt_q[gi] <= '0;
            end else begin
               case (st_q[gi])
                  BK_OFF: begin
                     st_q[gi] <= BK_SOFT;
                     cnt_q[gi] <= '0;
                  end
                  BK_SOFT: begin
                     if (soft_done[gi]) begin
                        st_q[gi] <= BK_ON;
                        cnt_q[gi] <= '0;
                     end else begin
                        cnt_q[gi] <= cnt_q[gi] + CNT_W'(1);
                     end
                  end
                  BK_ON: begin
                     if (hiccup_evt[gi]) begin
                        st_q[gi] <= BK_HICCUP;
                        cnt_q[gi] <= '0;
                     end else if (overcurrent[gi]) begin
                        cnt_q[gi] <= cnt_q[gi] + CNT_W'(1);
                     end else begin
                        cnt_q[gi] <= '0;
                     end
                  end
                  BK_HICCUP: begin
                     if (cnt_q[gi] >= HIC_CYC - CNT_W'(1)) begin
                        st_q[gi] <= BK_SOFT;
                        cnt_q[gi] <= '0;
                     end else begin
                        cnt_q[gi] <= cnt_q[gi] + CNT_W'(1);
                     end
                  end
                  default: st_q[gi] <= BK_OFF;
               endcase
            end
         end
      end
   endgenerate

   // ----------------------------------------
   // Power good and driver supply
   // ----------------------------------------
   localparam logic [CNT_W-1:0] PG_CYC = CNT_W'(PG_DEGLITCH_CYC);
   logic [CNT_W-1:0] pg_cnt_q;
   logic pg_cand;
   logic pg_q;
   logic all_on;

   always_comb begin
      all_on = 1'b1;
      for (int i = 0; i < NBUCK; i++) begin
         if (st_q[i] != BK_ON) begin
            all_on = 1'b0;
         end
      end
   end

   assign pg_cand = !input_low_lockout && !over_temp && (&en_vec) && all_on
                    && (&in_regulation) && (&(~buck_soft_start));

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         pg_cnt_q <= '0;
         pg_q <= 1'b0;
      end else if (!pg_cand) begin
         pg_cnt_q <= '0;
         pg_q <= 1'b0;
      end else if (pg_cnt_q >= PG_CYC - CNT_W'(1)) begin
         pg_q <= 1'b1;
      end else begin
         pg_cnt_q <= pg_cnt_q + CNT_W'(1);
      end
   end
   assign output_regulation_ok = pg_q;

   logic drv_q;
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         drv_q <= 1'b0;
      end else begin
         drv_q <= (|enable_wake) && !input_low_lockout;
      end
   end
   assign internal_driver_supply = drv_q;

   // ----------------------------------------
   // Events and interrupt
   // ----------------------------------------
   logic [NEVT-1:0] irq_stat_q;
   logic [NEVT-1:0] irq_mask_q;
   logic [NEVT-1:0] evt;
   logic pg_prev_q;
   logic ot_prev_q;
   logic lo_prev_q;
   logic wr_acc;
   logic [NEVT-1:0] w1c;

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         pg_prev_q <= 1'b0;
         ot_prev_q <= 1'b0;
         lo_prev_q <= 1'b0;
      end else begin
         pg_prev_q <= pg_q;
         ot_prev_q <= over_temp;
         lo_prev_q <= input_low_lockout;
      end
   end

   always_comb begin
      evt = '0;
      evt[EVT_PG_RISE] = pg_q && !pg_prev_q;
      evt[EVT_PG_FALL] = !pg_q && pg_prev_q;
      evt[EVT_HICCUP] = |hiccup_evt;
      evt[EVT_THERMAL] = over_temp && !ot_prev_q;
      evt[EVT_LOCKOUT] = input_low_lockout && !lo_prev_q;
      evt[EVT_SEQ_DONE] = seq_done_evt;
   end

   assign wr_acc = psel && penable && pwrite;
   assign w1c = (wr_acc && paddr == ADDR_IRQ_STAT) ? pwdata[NEVT-1:0] : '0;

   // A new event wins over a clear in the same cycle
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         irq_stat_q <= '0;
      end else begin
         irq_stat_q <= (irq_stat_q & ~w1c) | evt;
      end
   end
   assign irq = |(irq_stat_q & irq_mask_q);

   // ----------------------------------------
   // APB slave
   // ----------------------------------------
   logic [31:0] rdata_q;
   logic err_q;
   logic mapped;

   assign mapped = (paddr == ADDR_CTRL) || (paddr == ADDR_STATUS)
                   || (paddr == ADDR_IRQ_STAT) || (paddr == ADDR_IRQ_MASK);

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         ctrl_q <= '{hold_off: CTRL_RESET};
         irq_mask_q <= IRQ_MASK_RESET;
      end else if (wr_acc && paddr == ADDR_CTRL) begin
         ctrl_q.hold_off <= pwdata[CTRL_HOLD_BIT];
      end else if (wr_acc && paddr == ADDR_IRQ_MASK) begin
         irq_mask_q <= pwdata[NEVT-1:0];
      end
   end

   // Read data is captured in the setup cycle so it comes from flip-flops
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         rdata_q <= '0;
         err_q <= 1'b0;
      end else if (psel && !penable) begin
         err_q <= !mapped;
         case (paddr)
            ADDR_CTRL: rdata_q <= {31'h0, ctrl_q.hold_off};
            ADDR_STATUS: rdata_q <= {19'h0, input_low_lockout, over_temp, pg_q, sq_q,
                                     step_q, st_q[2], st_q[1], st_q[0]};
            ADDR_IRQ_STAT: rdata_q <= {26'h0, irq_stat_q};
            ADDR_IRQ_MASK: rdata_q <= {26'h0, irq_mask_q};
            default: rdata_q <= '0;
         endcase
      end
   end

   assign pready = psel && penable;
   assign prdata = rdata_q;
   assign pslverr = psel && penable && err_q;

endmodule : psq_sequencer

// ---- verif/psq_far_side.sv ----
// Far side model: controller, enable pin ramps and converter feedback
`timescale 1ns/100ps
module psq_far_side
   import psq_pkg::*;
#(
   parameter int RAMP_CYC = 30
) (
   input wire logic clk,
   input wire logic rst,
   input wire psq_enables_s cmd,
   input wire logic [NBUCK-1:0] buck_run,
   input wire logic [NBUCK-1:0] buck_soft_start,
   output psq_enables_s enables,
   output logic [NBUCK-1:0] enable_wake,
   output logic [NBUCK-1:0] in_regulation,
   output logic ramp_pin_buck1_done
);
   // ----
   // Pins and feedback
   // ----
   logic [NBUCK-1:0][1:0] lvl_q;
   logic [7:0] ramp_q;
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         lvl_q <= '0;
      end else begin
         for (int i = 0; i < NBUCK; i++) begin
            // Pull-down empties the pin cap at once, so stop is never late
            if (!cmd[i]) lvl_q[i] <= 2'h0;
            else if (lvl_q[i] != 2'h3) lvl_q[i] <= lvl_q[i] + 2'h1;
         end
      end
   end
   always_comb begin
      for (int i = 0; i < NBUCK; i++) begin
         enable_wake[i] = lvl_q[i] != 2'h0;
         enables[i] = lvl_q[i] == 2'h3;
      end
   end
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         ramp_q <= 8'h0;
         in_regulation <= 3'h0;
      end else begin
         ramp_q <= buck_soft_start[0] ? ramp_q + 8'h1 : 8'h0;
         in_regulation <= buck_run & ~buck_soft_start;
      end
   end
   assign ramp_pin_buck1_done = ramp_q >= 8'(RAMP_CYC);
endmodule : psq_far_side

// ---- verif/psq_sequencer_checker.sv ----
// Port assertions for the triple buck sequencer
`timescale 1ns/100ps
module psq_sequencer_checker
   import psq_pkg::*;
#(
   parameter logic [CNT_W-1:0] SS_CYC = CNT_W'(SOFTSTART_CYC),
   parameter logic [CNT_W-1:0] OCW_CYC = CNT_W'(OC_WAIT_CYC)
) (
   input wire logic clk,
   input wire logic rst,
   input wire logic psel,
   input wire logic penable,
   input wire logic pready,
   input wire logic pslverr,
   input wire logic sequencing_mode,
   input wire psq_enables_s enables,
   input wire logic [NBUCK-1:0] enable_wake,
   input wire logic input_low_lockout,
   input wire logic over_temp,
   input wire logic [NBUCK-1:0] overcurrent,
   input wire logic [NBUCK-1:0] in_regulation,
   input wire logic [NBUCK-1:0] buck_run,
   input wire logic [NBUCK-1:0] buck_soft_start,
   input wire logic internal_driver_supply,
   input wire logic output_regulation_ok
);
   // ----
   // Helper counters
   // ----
   logic cand;
   logic [12:0] pg_q;
   logic [CNT_W-1:0] s2_q, s3_q, oc_q;
   assign cand = !input_low_lockout && !over_temp && (&enables) && (&buck_run)
      && !(|buck_soft_start) && (&in_regulation);
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         pg_q <= '0;
         s2_q <= '0;
         s3_q <= '0;
         oc_q <= '0;
      end else begin
         pg_q <= !cand ? 13'h0 : (&pg_q ? pg_q : pg_q + 13'h1);
         s2_q <= buck_soft_start[1] ? s2_q + 1'b1 : '0;
         s3_q <= buck_soft_start[2] ? s3_q + 1'b1 : '0;
         oc_q <= (overcurrent[0] && buck_run[0] && !buck_soft_start[0]) ? oc_q + 1'b1 : '0;
      end
   end
   default clocking cb @(posedge clk); endclocking
   default disable iff (rst);
   // ----
   // Assertions
   // ----
   a_apb_ready: assert property (pready == (psel && penable) && (pready || !pslverr))
      else $error("APB ready or error out of place");
   a_kill_off: assert property ((input_low_lockout || over_temp) |=> buck_run == 3'h0)
      else $error("Buck still running after lockout or thermal stop");
   a_wake_supply: assert property ((|enable_wake && !input_low_lockout) [*2] |-> internal_driver_supply)
      else $error("Driver supply off while an enable is awake");
   a_pg_forced_low: assert property (!cand |=> !output_regulation_ok)
      else $error("Regulation flag high without its conditions");
   a_pg_deglitch: assert property ($rose(output_regulation_ok) |-> pg_q >= 13'(PG_DEGLITCH_CYC - 2))
      else $error("Regulation flag rose before the deglitch time");
   a_pg_late: assert property (pg_q == 13'(PG_DEGLITCH_CYC + 2) |-> output_regulation_ok)
      else $error("Regulation flag late");
   a_soft_buck2: assert property ($fell(buck_soft_start[1]) && buck_run[1] |-> s2_q inside {[SS_CYC - 1:SS_CYC + 1]})
      else $error("Buck2 soft start length wrong");
   a_soft_buck3: assert property ($fell(buck_soft_start[2]) && buck_run[2] |-> s3_q inside {[SS_CYC - 1:SS_CYC + 1]})
      else $error("Buck3 soft start length wrong");
   a_oc_shutdown: assert property (oc_q == OCW_CYC + 2 |-> !buck_run[0])
      else $error("Overcurrent did not stop buck1");
   a_indep_stop: assert property (!sequencing_mode && !$past(sequencing_mode) && !enables.buck2 |=> !buck_run[1])
      else $error("Buck2 runs with its enable low");
   a_reserved_off: assert property (sequencing_mode && enables[1:0] == 2'h0 && buck_run == 3'h0 |=> buck_run == 3'h0)
      else $error("Buck started with reserved order");
   a_buck3_after2: assert property (sequencing_mode && $past(sequencing_mode) && $rose(buck_run[2]) |-> buck_run[1] && !buck_soft_start[1])
      else $error("Buck3 started before buck2 was on");
   a_stop_order: assert property (sequencing_mode && $past(sequencing_mode) && $fell(buck_run[0]) && enables[1:0] == 2'h3 |-> buck_run[2:1] == 2'h0)
      else $error("Buck1 stopped before bucks 2 and 3");
   c_pg_rise: cover property ($rose(output_regulation_ok));
   c_hiccup: cover property ($fell(buck_run[0]) && overcurrent[0]);
   c_auto_all: cover property (sequencing_mode && buck_run == 3'h7);
endmodule : psq_sequencer_checker
bind psq_sequencer psq_sequencer_checker #(.SS_CYC(SS_CYC), .OCW_CYC(OCW_CYC)) psq_sequencer_checker_inst (
   .clk(clk), .rst(rst), .psel(psel), .penable(penable), .pready(pready), .pslverr(pslverr),
   .sequencing_mode(sequencing_mode), .enables(enables), .enable_wake(enable_wake),
   .input_low_lockout(input_low_lockout), .over_temp(over_temp), .overcurrent(overcurrent),
   .in_regulation(in_regulation), .buck_run(buck_run), .buck_soft_start(buck_soft_start),
   .internal_driver_supply(internal_driver_supply), .output_regulation_ok(output_regulation_ok));

// ---- verif/test_psq_sequencer.sv ----
// Self-checking bench for the triple buck sequencer
`timescale 1ns/100ps
`define CHK(g, e) begin n_tests++; if ((g) !== (e)) begin n_mismatch++; \
$display("MISMATCH t=%0t got %0h exp %0h", $time, g, e); end end
`define WT(c) for (n = 0; n < 6000 && !(c); n++) cyc(1); \
if (!(c)) begin n_mismatch++; $display("MISMATCH t=%0t wait ran out", $time); end
module test_psq_sequencer
   import psq_pkg::*;
;
   // ----
   // Signals and instances
   // ----
   localparam int SS = 50, OCW = 20, HIC = 100;
   logic clk, rst, psel, penable, pwrite, pready, pslverr, sequencing_mode, input_low_lockout;
   logic over_temp, internal_driver_supply, output_regulation_ok, irq, ramp_pin_buck1_done, er;
   logic [7:0] paddr;
   logic [31:0] pwdata, prdata, rd;
   logic [2:0] enable_wake, overcurrent, in_regulation, buck_run, buck_soft_start, run_q;
   psq_enables_s enables, cmd;
   int n_mismatch = 0, n_tests = 0, n, seed;
   logic [1:0] up_q[$], dn_q[$];
   logic [1:0] sel_t[3] = '{2'h3, 2'h2, 2'h1};
   psq_sequencer #(.SS_CYC(20'(SS)), .OCW_CYC(20'(OCW)), .HIC_CYC(20'(HIC))) psq_sequencer_inst (
      .clk(clk), .rst(rst), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
      .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .sequencing_mode(sequencing_mode), .enables(enables), .enable_wake(enable_wake),
      .input_low_lockout(input_low_lockout), .over_temp(over_temp), .overcurrent(overcurrent),
      .in_regulation(in_regulation), .ramp_pin_buck1_done(ramp_pin_buck1_done),
      .buck_run(buck_run), .buck_soft_start(buck_soft_start), .irq(irq),
      .internal_driver_supply(internal_driver_supply), .output_regulation_ok(output_regulation_ok));
   psq_far_side psq_far_side_inst (.clk(clk), .rst(rst), .cmd(cmd), .buck_run(buck_run),
      .buck_soft_start(buck_soft_start), .enables(enables), .enable_wake(enable_wake),
      .in_regulation(in_regulation), .ramp_pin_buck1_done(ramp_pin_buck1_done));
   // Logged on change, so the queues are settled before the next edge reads them
   always @(buck_run) begin
      for (int i = 0; i < 3; i++) begin
         if (buck_run[i] === 1'h1 && run_q[i] !== 1'h1) up_q.push_back(2'(i));
         if (buck_run[i] === 1'h0 && run_q[i] === 1'h1) dn_q.push_back(2'(i));
      end
      run_q = buck_run;
   end
   // ----
   // Tasks and functions
   // ----
   task automatic cyc(input int k);
      repeat (k) @(posedge clk);
   endtask : cyc
   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      @(posedge clk);
      psel <= 1'h1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge clk);
      penable <= 1'h1;
      do @(posedge clk); while (pready !== 1'h1);
      rd = prdata;
      er = pslverr;
      psel <= 1'h0;
      penable <= 1'h0;
   endtask : apb
   function automatic logic [5:0] exp_order(input logic [1:0] sel, input logic up);
      logic [5:0] s;
      s = sel == 2'h3 ? 6'h06 : (sel == 2'h2 ? 6'h12 : 6'h18);
      return up ? s : {s[1:0], s[3:2], s[5:4]};
   endfunction : exp_order
   function automatic logic [5:0] order(input logic [1:0] q[$]);
      return q.size() == 3 ? {q[0], q[1], q[2]} : 6'h3f;
   endfunction : order
   task automatic print_verdict();
      $display("Checks %0d, mismatches %0d", n_tests, n_mismatch);
      if (n_mismatch == 0 && n_tests > 0) begin
         $display("*** PASS ***");
      end else begin
         $display("*** FAIL ***");
      end
      $finish;
   endtask : print_verdict
   // ----
   // Clock, watchdog, tests
   // ----
   initial begin
      clk = 1'h0;
      forever #12.5 clk = ~clk;
   end
   initial begin
      #1500000;
      n_mismatch++;
      $display("MISMATCH t=%0t watchdog expired", $time);
      print_verdict();
   end
   initial begin
      seed = $urandom(20936);
      {rst, psel, penable, pwrite, paddr, pwdata} = {1'h1, 43'h0};
      {sequencing_mode, input_low_lockout, over_temp, overcurrent} = 6'h0;
      cmd = 3'h0;
      cyc(6);
      rst <= 1'h0;
      apb(1'h0, ADDR_CTRL, 32'h0);
      `CHK(rd, 32'h0)
      apb(1'h0, ADDR_IRQ_MASK, 32'h0);
      `CHK(rd[NEVT-1:0], IRQ_MASK_RESET)
      apb(1'h1, 8'h10, 32'hffffffff);
      `CHK({er, rd}, 33'h100000000)
      apb(1'h1, ADDR_IRQ_MASK, 32'(1 << EVT_HICCUP));
      cmd <= 3'h2;
      cyc(3);
      `CHK({internal_driver_supply, enables.buck2}, 2'h2)
      `WT(buck_soft_start[1])
      `WT(!buck_soft_start[1])
      `CHK(n inside {[SS - 1:SS + 1]}, 1'h1)
      cmd <= 3'h7;
      `WT(&in_regulation)
      `WT(output_regulation_ok)
      `CHK(n inside {[PG_DEGLITCH_CYC - 3:PG_DEGLITCH_CYC + 3]}, 1'h1)
      `CHK(irq, 1'h0)
      overcurrent <= 3'h1;
      `WT(!buck_run[0])
      `CHK(n inside {[OCW - 1:OCW + 3]}, 1'h1)
      // Flag register drops one edge after the buck leaves its on state
      cyc(1);
      `CHK(output_regulation_ok, 1'h0)
      overcurrent <= 3'h0;
      `WT(buck_run[0])
      `CHK(n inside {[HIC - 1:HIC + 3]}, 1'h1)
      `CHK(irq, 1'h1)
      apb(1'h1, ADDR_IRQ_STAT, 32'(1 << EVT_HICCUP));
      cyc(1);
      `CHK(irq, 1'h0)
      input_low_lockout <= 1'h1;
      cyc(3);
      `CHK({buck_run, internal_driver_supply, output_regulation_ok}, 5'h0)
      input_low_lockout <= 1'h0;
      `WT(buck_run == 3'h7)
      `CHK(buck_run, 3'h7)
      for (int k = 0; k < 6; k++) begin
         cmd <= 3'($urandom % 7);
         cyc(250);
         `CHK({buck_run, output_regulation_ok}, {cmd, 1'h0})
      end
      cmd <= 3'h0;
      cyc(50);
      sequencing_mode <= 1'h1;
      for (int k = 0; k < 3; k++) begin
         cmd <= {1'h0, sel_t[k]};
         cyc(10);
         up_q.delete();
         cmd <= {1'h1, sel_t[k]};
         `WT(buck_run == 3'h7)
         `CHK(order(up_q), exp_order(sel_t[k], 1'h1))
         dn_q.delete();
         cmd <= {1'h0, sel_t[k]};
         `WT(buck_run == 3'h0)
         `CHK(order(dn_q), exp_order(sel_t[k], 1'h0))
      end
      cmd <= 3'h7;
      `WT(buck_run == 3'h7)
      over_temp <= 1'h1;
      cyc(3);
      `CHK(buck_run, 3'h0)
      up_q.delete();
      over_temp <= 1'h0;
      `WT(buck_run == 3'h7)
      `CHK(order(up_q), exp_order(2'h3, 1'h1))
      cmd <= 3'h0;
      `WT(buck_run == 3'h0)
      cmd <= 3'h4;
      cyc(300);
      `CHK(buck_run, 3'h0)
      print_verdict();
   end
endmodule : test_psq_sequencer
